// ---- rtl/hw_window_fetch.sv ----
// Hardware window video fetch scheduler with side-band pixel information.
`timescale 1ns/1ps
module hw_window_fetch #(
  parameter int DEPTH = win_fetch_pkg::FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic frame_start_event,
  input wire logic line_start,
  input wire win_fetch_pkg::win_cfg_t win_cfg,
  input wire logic [win_fetch_pkg::NPLANES-1:0][15:0] ser_word,
  input wire logic asm_ready,
  input wire logic glyph_req,
  input wire logic [win_fetch_pkg::COORD_W-1:0] glyph_x,
  input wire logic [win_fetch_pkg::TAKE_W-1:0] glyph_width,
  output logic vram_xfer,
  output logic vram_shift,
  output logic [win_fetch_pkg::COORD_W-1:0] vram_row,
  output logic [win_fetch_pkg::COL_W-1:0] vram_col,
  output logic asm_valid,
  output logic asm_xfer,
  output logic [win_fetch_pkg::INFO_W-1:0] video_fetch_info_lines,
  output logic [win_fetch_pkg::NPLANES-1:0][7:0] asm_bytes,
  output logic fetch_busy,
  output logic glyph_done,
  output logic glyph_two_writes
);

  // Width of one FIFO word: all planes plus side-band information.
  localparam int EW = $bits(win_fetch_pkg::fetch_entry_t);

  typedef struct packed {
    win_fetch_pkg::fetch_st_t st;
    win_fetch_pkg::win_cfg_t cfg;
    logic [win_fetch_pkg::COORD_W-1:0] line;
    logic [win_fetch_pkg::COORD_W-1:0] line_y;
    logic [1:0] seg;
    logic [win_fetch_pkg::COORD_W-1:0] cur_x;
    logic [win_fetch_pkg::LEN_W-1:0] rem;
    logic first;
    logic pend;
    win_fetch_pkg::vram_cmd_t vram;
    logic have;
    logic [1:0] ph;
    win_fetch_pkg::fetch_entry_t ent;
    win_fetch_pkg::asm_beat_t beat;
    logic glyph_done;
    logic glyph_two;
    logic busy;
  } top_st_t;

  top_st_t q;
  top_st_t d;

  // Handshake and data between the fetch side, the FIFO and the holder.
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic fifo_push;
  win_fetch_pkg::fetch_entry_t push_ent;
  logic [EW-1:0] fifo_out_raw;
  win_fetch_pkg::fetch_entry_t fifo_out;

  // Valid bits of one byte: overlap of the used span with the byte.
  function automatic logic [win_fetch_pkg::INFO_W-1:0] byte_cnt(
    input logic [win_fetch_pkg::TAKE_W-1:0] s,
    input logic [win_fetch_pkg::TAKE_W-1:0] take,
    input logic [win_fetch_pkg::TAKE_W-1:0] base
  );
    logic [win_fetch_pkg::TAKE_W:0] lo;
    logic [win_fetch_pkg::TAKE_W:0] hi;
    logic [win_fetch_pkg::TAKE_W:0] e;
    logic [win_fetch_pkg::TAKE_W:0] be;
    lo = {1'b0, s};
    e = {1'b0, s} + {1'b0, take};
    be = {1'b0, base} + {1'b0, win_fetch_pkg::BYTE_BITS};
    hi = (e < be) ? e : be;
    if ({1'b0, base} > lo) begin
      lo = {1'b0, base};
    end
    byte_cnt = (hi > lo) ? win_fetch_pkg::INFO_W'(hi - lo) : '0;
  endfunction

  // Column address: word part of X only, low bit-position bits dropped.
  function automatic logic [win_fetch_pkg::COL_W-1:0] word_col(
    input logic [win_fetch_pkg::COORD_W-1:0] x
  );
    word_col = x[win_fetch_pkg::COORD_W-1:win_fetch_pkg::BITPOS_W];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Segment planning for the current scan line.

  // Row offset into the window and bounds of the segment being planned.
  logic [win_fetch_pkg::COORD_W-1:0] dy;
  logic win_row;
  logic [win_fetch_pkg::LEN_W-1:0] seg_len;
  logic [win_fetch_pkg::COORD_W-1:0] seg_x;
  logic [win_fetch_pkg::COORD_W-1:0] seg_y;
  logic [win_fetch_pkg::COORD_W-1:0] right_x;

  // Window rows and segment bounds derived from the latched setup.
  always_comb begin
    dy = q.line_y - q.cfg.app_y;
    right_x = q.cfg.app_x + q.cfg.win_w[win_fetch_pkg::COORD_W-1:0];
    win_row = ({1'b0, dy} < q.cfg.win_h) && (q.cfg.win_w != '0) &&
              !((q.cfg.real_x == q.cfg.app_x) &&
                (q.cfg.real_y == q.cfg.app_y));
    seg_x = q.cfg.scr_x0;
    seg_y = q.line_y;
    seg_len = '0;
    if (!win_row) begin
      if (q.seg == win_fetch_pkg::SEG_LEFT) begin
        seg_len = q.cfg.line_w;
      end
    end else begin
      case (q.seg)
        win_fetch_pkg::SEG_LEFT: begin
          seg_len = win_fetch_pkg::LEN_W'(q.cfg.app_x - q.cfg.scr_x0);
        end
        win_fetch_pkg::SEG_WIN: begin
          seg_x = q.cfg.real_x;
          seg_y = q.cfg.real_y + dy;
          seg_len = q.cfg.win_w;
        end
        win_fetch_pkg::SEG_RIGHT: begin
          seg_x = right_x;
          seg_len = q.cfg.line_w -
                    win_fetch_pkg::LEN_W'(right_x - q.cfg.scr_x0);
        end
        default: begin
          seg_len = '0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Word split: bits of the current word that belong to the segment.

  // Start bit, free bits and used bits of the word now being shifted.
  logic [win_fetch_pkg::TAKE_W-1:0] s5;
  logic [win_fetch_pkg::TAKE_W-1:0] room;
  logic [win_fetch_pkg::TAKE_W-1:0] take;
  logic [win_fetch_pkg::LEN_W-1:0] rem_next;

  always_comb begin
    s5 = {1'b0, q.cur_x[win_fetch_pkg::BITPOS_W-1:0]};
    room = win_fetch_pkg::WORD_BITS - s5;
    take = (q.rem < win_fetch_pkg::LEN_W'(room)) ?
           q.rem[win_fetch_pkg::TAKE_W-1:0] : room;
    rem_next = q.rem - win_fetch_pkg::LEN_W'(take);
  end

  // Entry written into the FIFO for the word just shifted out.
  always_comb begin
    push_ent.word = ser_word;
    push_ent.xfer = q.first;
    push_ent.first_bit = q.cur_x[win_fetch_pkg::BITPOS_W-1:0];
    push_ent.cnt_hi = byte_cnt(s5, take, win_fetch_pkg::HI_BYTE_BASE);
    push_ent.cnt_lo = byte_cnt(s5, take, win_fetch_pkg::LO_BYTE_BASE);
  end

  // Push in the same cycle as the shift pulse; the holder pops whenever it is empty.
  assign fifo_push = (q.st == win_fetch_pkg::ST_SHIFT) && q.pend;
  assign fifo_out_ready = !q.have;
  assign fifo_out = win_fetch_pkg::fetch_entry_t'(fifo_out_raw);

  ////////////////////////////////////////////////////////////////////////////
  // Next state of the whole block.

  always_comb begin
    d = q;
    d.vram.xfer = 1'b0;
    d.vram.shift = 1'b0;
    d.glyph_done = 1'b0;

    if (glyph_req) begin
      d.glyph_done = 1'b1;
      d.glyph_two = ({1'b0, glyph_x[win_fetch_pkg::BITPOS_W-1:0]} +
                     {1'b0, glyph_width}) > {1'b0, win_fetch_pkg::WORD_BITS};
    end

    case (q.st)
      win_fetch_pkg::ST_IDLE: begin
        // A frame start wins over a line start in the same cycle.
        // setup taken at frame start
        if (frame_start_event) begin
          d.cfg = win_cfg;
          d.line = '0;
        end else if (line_start) begin
          d.line_y = q.cfg.scr_y0 + q.line;
          d.line = q.line + 1'b1;
          d.seg = win_fetch_pkg::SEG_LEFT;
          d.st = win_fetch_pkg::ST_PLAN;
        end
      end
      win_fetch_pkg::ST_PLAN: begin
        if (seg_len != '0) begin
          d.vram.xfer = 1'b1;
          d.vram.row = seg_y;
          d.vram.col = word_col(seg_x);
          d.cur_x = seg_x;
          d.rem = seg_len;
          d.first = 1'b1;
          d.pend = 1'b0;
          d.st = win_fetch_pkg::ST_SHIFT;
        end else if (q.seg == win_fetch_pkg::SEG_RIGHT) begin
          // Empty segments are skipped at one cycle each.
          d.st = win_fetch_pkg::ST_IDLE;
        end else begin
          d.seg = q.seg + 1'b1;
        end
      end
      win_fetch_pkg::ST_SHIFT: begin
        // The serial word stands only around the shift, so push then.
        if (q.pend) begin
          d.pend = 1'b0;
          d.first = 1'b0;
          d.cur_x = q.cur_x + win_fetch_pkg::COORD_W'(take);
          d.rem = rem_next;
          if (rem_next == '0) begin
            if (q.seg == win_fetch_pkg::SEG_RIGHT) begin
              d.st = win_fetch_pkg::ST_IDLE;
            end else begin
              d.seg = q.seg + 1'b1;
              d.st = win_fetch_pkg::ST_PLAN;
            end
          end
        end else if (fifo_in_ready) begin
          // Shift only with FIFO room, so the next push cannot be lost.
          d.vram.shift = 1'b1;
          d.pend = 1'b1;
        end
      end
      default: begin
        d.st = win_fetch_pkg::ST_IDLE;
      end
    endcase

    // Entry holder pulls from the FIFO whenever it is empty.
    // Refilling takes a cycle, so each word leaves a one-cycle beat gap.
    if (!q.have && fifo_out_valid) begin
      d.have = 1'b1;
      d.ent = fifo_out;
      d.ph = fifo_out.xfer ? win_fetch_pkg::PH_XFER : win_fetch_pkg::PH_HI;
    end

    // Beat stage: a new beat loads when the previous one is taken.
    if (!q.beat.valid || asm_ready) begin
      d.beat.valid = 1'b0;
      if (q.have) begin
        d.beat.valid = 1'b1;
        d.beat.xfer = 1'b0;
        d.beat.bytes = '0;
        case (q.ph)
          win_fetch_pkg::PH_XFER: begin
            d.beat.xfer = 1'b1;
            d.beat.info = q.ent.first_bit;
            d.ph = win_fetch_pkg::PH_HI;
          end
          win_fetch_pkg::PH_HI: begin
            d.beat.info = q.ent.cnt_hi;
            for (int p = 0; p < win_fetch_pkg::NPLANES; p++) begin
              d.beat.bytes[p] =
                q.ent.word[p][win_fetch_pkg::WORD_W-1:win_fetch_pkg::BYTE_W];
            end
            d.ph = win_fetch_pkg::PH_LO;
          end
          default: begin
            d.beat.info = q.ent.cnt_lo;
            for (int p = 0; p < win_fetch_pkg::NPLANES; p++) begin
              d.beat.bytes[p] = q.ent.word[p][win_fetch_pkg::BYTE_W-1:0];
            end
            d.have = 1'b0;
          end
        endcase
      end
    end

    // Busy is registered so that the port comes straight from a flop.
    d.busy = (d.st != win_fetch_pkg::ST_IDLE);
  end

  // Whole block state, frozen while the clock enable is low.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      q <= '0;
      q.st <= win_fetch_pkg::ST_IDLE;
    end else if (ce) begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Look-ahead word buffer between fetch and assembler beats.

  word_fifo #(
    .W(EW),
    .DEPTH(DEPTH)
  ) word_fifo_i (
    .clk(clk),
    .rstn(rstn),
    .ce(ce),
    .in_valid(fifo_push),
    .in_ready(fifo_in_ready),
    .in_data(push_ent),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_raw)
  );

  // Every port is read straight from the registered state.
  // plain 8 data bits per plane
  assign vram_xfer = q.vram.xfer;
  assign vram_shift = q.vram.shift;
  assign vram_row = q.vram.row;
  assign vram_col = q.vram.col;
  assign asm_valid = q.beat.valid;
  assign asm_xfer = q.beat.xfer;
  assign video_fetch_info_lines = q.beat.info;
  assign asm_bytes = q.beat.bytes;
  assign fetch_busy = q.busy;
  assign glyph_done = q.glyph_done;
  assign glyph_two_writes = q.glyph_two;

endmodule

// ---- rtl/win_fetch_pkg.sv ----
// Constants, carrier types and summary of the hardware window video fetch.
// Summary of operation
// - Memory fetched and shifted as 16-bit plane words
// - No window: one transfer per scan line
// - Window line: transfers at left and right edge
// - Transfer beat reports first valid bit position
// - Each byte beat reports its valid bit count
// - Window transfer reports first bit, then counts
// - Window is rectangle, any size, bit position
// - Window shows real image, memory left untouched
// - All four planes replaced inside the window
// - Real origin equal apparent origin: no window
// - Twelve address bits; low four X bits unused
// - Bit or nibble wide memory handled identically
// - Glyph row straddling word needs two writes
package win_fetch_pkg;

  localparam int WORD_W = 16;
  localparam int BYTE_W = 8;
  localparam int NPLANES = 4;
  localparam int COORD_W = 12;
  localparam int LEN_W = 13;
  localparam int BITPOS_W = 4;
  localparam int INFO_W = 4;
  localparam int TAKE_W = 5;
  localparam int COL_W = COORD_W - BITPOS_W;
  localparam int FIFO_DEPTH = 32;
  localparam int NSEG = 3;

  localparam logic [TAKE_W-1:0] WORD_BITS = 5'h10;
  localparam logic [TAKE_W-1:0] BYTE_BITS = 5'h08;
  localparam logic [TAKE_W-1:0] HI_BYTE_BASE = 5'h00;
  localparam logic [TAKE_W-1:0] LO_BYTE_BASE = 5'h08;
  localparam logic [1:0] SEG_LEFT = 2'h0;
  localparam logic [1:0] SEG_WIN = 2'h1;
  localparam logic [1:0] SEG_RIGHT = 2'h2;
  localparam logic [1:0] PH_XFER = 2'h0;
  localparam logic [1:0] PH_HI = 2'h1;
  localparam logic [1:0] PH_LO = 2'h2;

  // Window and screen setup, all coordinates in display memory pixels.
  typedef struct packed {
    logic [COORD_W-1:0] scr_x0;
    logic [COORD_W-1:0] scr_y0;
    logic [LEN_W-1:0] line_w;
    logic [COORD_W-1:0] app_x;
    logic [COORD_W-1:0] app_y;
    logic [LEN_W-1:0] win_w;
    logic [LEN_W-1:0] win_h;
    logic [COORD_W-1:0] real_x;
    logic [COORD_W-1:0] real_y;
  } win_cfg_t;

  // One fetched word of all planes with its side-band information.
  typedef struct packed {
    logic [NPLANES-1:0][WORD_W-1:0] word;
    logic xfer;
    logic [BITPOS_W-1:0] first_bit;
    logic [INFO_W-1:0] cnt_hi;
    logic [INFO_W-1:0] cnt_lo;
  } fetch_entry_t;

  // Commands to the video memory.
  typedef struct packed {
    logic xfer;
    logic shift;
    logic [COORD_W-1:0] row;
    logic [COL_W-1:0] col;
  } vram_cmd_t;

  // One beat towards the external assembler.
  typedef struct packed {
    logic valid;
    logic xfer;
    logic [INFO_W-1:0] info;
    logic [NPLANES-1:0][BYTE_W-1:0] bytes;
  } asm_beat_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_PLAN = 3'h2,
    ST_SHIFT = 3'h4
  } fetch_st_t;

endpackage

// ---- rtl/word_fifo.sv ----
// Synchronous flip-flop FIFO with valid and ready on both sides.
`timescale 1ns/1ps
module word_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 32
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } fifo_st_t;

  fifo_st_t q;
  fifo_st_t d;
  logic push;
  logic pop;

  // Flags come straight from the occupancy count.
  assign in_ready = (q.cnt != (AW+1)'(DEPTH));
  assign out_valid = (q.cnt != '0);
  assign out_data = q.mem[q.rp];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Pointer and count update; a simultaneous push and pop keeps the count.
  always_comb begin
    d = q;
    if (push) begin
      d.mem[q.wp] = in_data;
      d.wp = (q.wp == AW'(DEPTH - 1)) ? '0 : q.wp + 1'b1;
    end
    if (pop) begin
      d.rp = (q.rp == AW'(DEPTH - 1)) ? '0 : q.rp + 1'b1;
    end
    if (push && !pop) begin
      d.cnt = q.cnt + 1'b1;
    end else if (pop && !push) begin
      d.cnt = q.cnt - 1'b1;
    end
  end

  // State register, frozen while the clock enable is low.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      q <= '0;
    end else if (ce) begin
      q <= d;
    end
  end

endmodule

// ---- verif/asm_vram_model.sv ----
// Video memory serial port and assembler model for the fetch block.
`timescale 1ns/1ps
module asm_vram_model (
  input wire logic clk,
  input wire logic vram_xfer,
  input wire logic vram_shift,
  input wire logic [11:0] vram_row,
  input wire logic [7:0] vram_col,
  input wire logic stall,
  output logic [3:0][15:0] ser_word,
  output logic asm_ready
);
  logic [7:0] col_q = 8'h00;
  logic sh_q = 1'b0;
  // A transfer loads the column; each shift advances one 16-bit word.
  always @(posedge clk) begin
    sh_q <= vram_shift;
    if (vram_xfer) begin
      col_q <= vram_col;
    end else if (sh_q) begin
      col_q <= col_q + 8'h01;
    end
  end
  // sixteen bits per plane
  // Word shows during the shift and the next cycle, else it is scrambled.
  always_comb begin
    for (int p = 0; p < 4; p++) begin
      ser_word[p] = {2'(p), vram_row[5:0], col_q};
      if (!(vram_shift || sh_q)) begin
        ser_word[p] = ~ser_word[p];
      end
    end
  end
  assign asm_ready = !stall;
endmodule

// ---- verif/hw_window_fetch_bench.sv ----
// Self-checking bench for the hardware window video fetch.
`timescale 1ns/1ps
module hw_window_fetch_bench;
  localparam int DEPTH = 32;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic ce = 1'b1;
  logic frame_start_event = 1'b0;
  logic line_start = 1'b0;
  win_fetch_pkg::win_cfg_t win_cfg = '0;
  logic [3:0][15:0] ser_word;
  logic asm_ready;
  logic stall = 1'b0;
  logic glyph_req = 1'b0;
  logic [11:0] glyph_x = 12'h000;
  logic [4:0] glyph_width = 5'h00;
  logic vram_xfer, vram_shift, asm_valid, asm_xfer, fetch_busy;
  logic glyph_done, glyph_two_writes;
  logic [11:0] vram_row;
  logic [7:0] vram_col;
  logic [3:0] info;
  logic [3:0][7:0] asm_bytes;
  int n_errors = 0;
  int checks = 0;
  int n_shift = 0;
  logic [19:0] xq[$], exq[$];
  logic [36:0] bq[$], ebq[$];

  hw_window_fetch #(.DEPTH(DEPTH)) hw_window_fetch_i (.clk(clk),
    .rstn(rstn), .ce(ce), .frame_start_event(frame_start_event),
    .line_start(line_start), .win_cfg(win_cfg), .ser_word(ser_word),
    .asm_ready(asm_ready), .glyph_req(glyph_req), .glyph_x(glyph_x),
    .glyph_width(glyph_width), .vram_xfer(vram_xfer),
    .vram_shift(vram_shift), .vram_row(vram_row), .vram_col(vram_col),
    .asm_valid(asm_valid), .asm_xfer(asm_xfer),
    .video_fetch_info_lines(info), .asm_bytes(asm_bytes),
    .fetch_busy(fetch_busy), .glyph_done(glyph_done),
    .glyph_two_writes(glyph_two_writes));
  asm_vram_model asm_vram_model_i (.clk(clk), .vram_xfer(vram_xfer),
    .vram_shift(vram_shift), .vram_row(vram_row), .vram_col(vram_col),
    .stall(stall), .ser_word(ser_word), .asm_ready(asm_ready));

  // Clock of 20 ns period.
  always #10 clk = ~clk;

  // Record transfers, shifts and every beat taken by the assembler.
  always @(posedge clk) begin
    if (rstn) begin
      if (vram_xfer) xq.push_back({vram_row, vram_col});
      if (vram_shift) n_shift++;
      if (asm_valid && asm_ready) bq.push_back({asm_xfer, info, asm_bytes});
    end
  end

  function automatic win_fetch_pkg::win_cfg_t cfg(int x0, int y0, int lw,
      int ax, int ay, int ww, int wh, int rx, int ry);
    return '{12'(x0), 12'(y0), 13'(lw), 12'(ax), 12'(ay), 13'(ww),
      13'(wh), 12'(rx), 12'(ry)};
  endfunction

  task automatic chk(input string what, input logic [63:0] e,
      input logic [63:0] g);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s expected %0h seen %0h", what, e, g);
    end
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // Expected beat: plane p of word (r, c) is {p, r[5:0], c}.
  task automatic eb(input logic x, input logic [3:0] n,
      input logic [11:0] r, input logic [7:0] c, input logic hi);
    logic [15:0] w;
    logic [3:0][7:0] b;
    for (int p = 0; p < 4; p++) begin
      w = {2'(p), r[5:0], c};
      b[p] = x ? 8'h00 : (hi ? w[15:8] : w[7:0]);
    end
    ebq.push_back({x, n, b});
  endtask

  task automatic ew(input logic [11:0] r, input logic [7:0] c,
      input logic [3:0] nh, input logic [3:0] nl);
    eb(1'b0, nh, r, c, 1'b1);
    eb(1'b0, nl, r, c, 1'b0);
  endtask

  task automatic ex(input logic [11:0] r, input logic [7:0] c, int fb);
    exq.push_back({r, c});
    eb(1'b1, 4'(fb), 12'h000, 8'h00, 1'b1);
  endtask

  task automatic go(input win_fetch_pkg::win_cfg_t c);
    xq.delete();
    bq.delete();
    exq.delete();
    ebq.delete();
    n_shift = 0;
    win_cfg <= c;
    @(posedge clk);
    frame_start_event <= 1'b1;
    @(posedge clk);
    frame_start_event <= 1'b0;
    line_start <= 1'b1;
    @(posedge clk);
    line_start <= 1'b0;
  endtask

  task automatic wait_idle();
    int quiet;
    quiet = 0;
    for (int i = 0; i < 3000 && quiet < 8; i++) begin
      @(posedge clk);
      quiet = (fetch_busy === 1'b0 && asm_valid === 1'b0) ? quiet + 1 : 0;
    end
    chk("idle reached", 64'h8, 64'(quiet));
  endtask

  task automatic judge();
    chk("xfer count", 64'(exq.size()), 64'(xq.size()));
    foreach (exq[i]) begin
      if (i < xq.size()) chk("xfer addr", 64'(exq[i]), 64'(xq[i]));
    end
    chk("beat count", 64'(ebq.size()), 64'(bq.size()));
    foreach (ebq[i]) begin
      if (i < bq.size()) chk("beat", 64'(ebq[i]), 64'(bq[i]));
    end
  endtask

  task automatic t_plain();
    go(cfg(16, 5, 32, 0, 0, 0, 0, 0, 0));
    repeat (2) @(posedge clk);
    line_start <= 1'b1;
    @(posedge clk);
    line_start <= 1'b0;
    ex(12'h005, 8'h01, 0);
    ew(12'h005, 8'h01, 4'h8, 4'h8);
    ew(12'h005, 8'h02, 4'h8, 4'h8);
    wait_idle();
    judge();
    $display("test plain line done");
  endtask

  task automatic t_window();
    go(cfg(0, 0, 48, 8, 0, 16, 4, 12'h100, 12'h040));
    ex(12'h000, 8'h00, 0);
    ew(12'h000, 8'h00, 4'h8, 4'h0);
    ex(12'h040, 8'h10, 0);
    ew(12'h040, 8'h10, 4'h8, 4'h8);
    ex(12'h000, 8'h01, 8);
    ew(12'h000, 8'h01, 4'h0, 4'h8);
    ew(12'h000, 8'h02, 4'h8, 4'h8);
    wait_idle();
    judge();
    $display("test window line done");
  endtask

  task automatic t_same();
    go(cfg(0, 0, 48, 8, 0, 16, 4, 8, 0));
    ex(12'h000, 8'h00, 0);
    for (int c = 0; c < 3; c++) ew(12'h000, 8'(c), 4'h8, 4'h8);
    wait_idle();
    judge();
    $display("test equal origin done");
  endtask

  // A line start while the clock enable is low must leave the block idle.
  task automatic t_freeze();
    ce <= 1'b0;
    line_start <= 1'b1;
    repeat (3) @(posedge clk);
    ce <= 1'b1;
    line_start <= 1'b0;
    #1;
    chk("frozen busy", 64'h0, 64'(fetch_busy));
    repeat (4) @(posedge clk);
    chk("frozen xfers", 64'h1, 64'(xq.size()));
    $display("test clock enable hold done");
  endtask

  task automatic t_fill();
    stall <= 1'b1;
    go(cfg(0, 0, 1024, 0, 0, 0, 0, 0, 0));
    repeat (300) @(posedge clk);
    chk("busy while full", 64'h1, 64'(fetch_busy));
    chk("shifts", 64'h1, 64'(n_shift inside {[DEPTH:DEPTH+3]}));
    stall <= 1'b0;
    wait_idle();
    chk("beats drained", 64'h81, 64'(bq.size()));
    chk("last count", 64'h8, 64'(bq[$][35:32]));
    $display("test fill and drain done");
  endtask

  task automatic t_glyph();
    logic [11:0] xs[4] = '{12'h00C, 12'h000, 12'h008, 12'h001};
    logic [4:0] ws[4] = '{5'h08, 5'h10, 5'h08, 5'h10};
    logic [3:0] two = 4'b1001;
    for (int i = 0; i < 4; i++) begin
      glyph_x <= xs[i];
      glyph_width <= ws[i];
      glyph_req <= 1'b1;
      @(posedge clk);
      glyph_req <= 1'b0;
      #1;
      chk("glyph done", 64'h1, 64'(glyph_done));
      chk("two writes", 64'(two[i]), 64'(glyph_two_writes));
      @(posedge clk);
    end
    $display("test glyph straddle done");
  endtask

  // Main sequence after a reset of 12 cycles.
  initial begin
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    t_plain();
    t_window();
    t_same();
    t_freeze();
    t_fill();
    t_glyph();
    wrap_up();
  end

  // Watchdog well beyond the expected run length.
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    $display("watchdog expired");
    wrap_up();
  end
endmodule

bind hw_window_fetch win_fetch_checker win_fetch_checker_i (.clk(clk),
  .rstn(rstn), .ce(ce), .frame_start_event(frame_start_event),
  .line_start(line_start), .asm_ready(asm_ready), .glyph_req(glyph_req),
  .glyph_x(glyph_x), .glyph_width(glyph_width), .vram_xfer(vram_xfer),
  .vram_shift(vram_shift), .vram_row(vram_row), .vram_col(vram_col),
  .asm_valid(asm_valid), .asm_xfer(asm_xfer),
  .video_fetch_info_lines(video_fetch_info_lines), .asm_bytes(asm_bytes),
  .fetch_busy(fetch_busy), .glyph_done(glyph_done),
  .glyph_two_writes(glyph_two_writes));

// ---- verif/win_fetch_checker.sv ----
// Port assertions for the hardware window video fetch.
`timescale 1ns/1ps
module win_fetch_checker (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic frame_start_event,
  input wire logic line_start,
  input wire logic asm_ready,
  input wire logic glyph_req,
  input wire logic [win_fetch_pkg::COORD_W-1:0] glyph_x,
  input wire logic [win_fetch_pkg::TAKE_W-1:0] glyph_width,
  input wire logic vram_xfer,
  input wire logic vram_shift,
  input wire logic [win_fetch_pkg::COORD_W-1:0] vram_row,
  input wire logic [win_fetch_pkg::COL_W-1:0] vram_col,
  input wire logic asm_valid,
  input wire logic asm_xfer,
  input wire logic [win_fetch_pkg::INFO_W-1:0] video_fetch_info_lines,
  input wire logic [win_fetch_pkg::NPLANES-1:0][7:0] asm_bytes,
  input wire logic fetch_busy,
  input wire logic glyph_done,
  input wire logic glyph_two_writes
);
  logic [4:0] span;
  logic [36:0] beat;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // Helper values for the glyph span and the whole assembler beat.
  assign span = 5'(glyph_x[3:0]) + glyph_width;
  assign beat = {asm_xfer, video_fetch_info_lines, asm_bytes};
  property p_start;
    ce && line_start && !frame_start_event && !fetch_busy
      |-> ##[2:4] vram_xfer;
  endproperty
  a_start: assert property (p_start) else $error("no transfer");
  property p_xfer_once;
    vram_xfer |=> !vram_xfer;
  endproperty
  a_xfer_once: assert property (p_xfer_once)
    else $error("long xfer");
  property p_shift_gap;
    vram_shift |=> !vram_shift;
  endproperty
  a_shift_gap: assert property (p_shift_gap)
    else $error("shift gap");
  property p_idle_quiet;
    !fetch_busy && !$past(fetch_busy) |-> !vram_xfer && !vram_shift;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet)
    else $error("idle cmd");
  property p_addr_hold;
    !vram_xfer |-> $stable({vram_row, vram_col});
  endproperty
  a_addr_hold: assert property (p_addr_hold)
    else $error("addr moved");
  property p_xfer_beat;
    asm_valid && asm_xfer |-> asm_bytes == '0;
  endproperty
  a_xfer_beat: assert property (p_xfer_beat)
    else $error("xfer data");
  property p_count;
    asm_valid && !asm_xfer |-> video_fetch_info_lines <= 4'h8;
  endproperty
  a_count: assert property (p_count) else $error("count range");
  property p_hold;
    asm_valid && !asm_ready |=> asm_valid && $stable(beat);
  endproperty
  a_hold: assert property (p_hold) else $error("beat dropped");
  property p_glyph;
    glyph_req |=> glyph_done && glyph_two_writes == ($past(span) > 5'h10);
  endproperty
  a_glyph: assert property (p_glyph) else $error("glyph result");
  c_xfer: cover property (vram_xfer);
  c_stall: cover property (asm_valid && !asm_ready);
  c_two: cover property (glyph_done && glyph_two_writes);
endmodule
